/* File: src/pmu_filter_pkg.sv */
// Constants, field positions and types for the counter filter registers.
// Functional notes
// [RQ1] Cycle filter bit 31 set blocks kernel counting.
// [RQ2] Cycle filter bit 30 set blocks user counting.
// [RQ3] Nonsecure kernel counts only if bit29 equals bit31.
// [RQ4] Nonsecure user counts only if bit28 equals bit30.
// [RQ5] Bit 27 enables hypervisor counting; zero if absent.
// [RQ6] Monitor counts only if bit 26 equals bit 31.
// [RQ7] Secure hypervisor counts if bit 24 differs from 27.
// [RQ8] Isolated kernel counts if bit 22 equals bit 31.
// [RQ9] Isolated user counts if bit 21 equals bit 30.
// [RQ10] Isolated hypervisor counts if bit 20 differs from 27.
// [RQ11] Reset clears fields for narrow state, else kept.
// [RQ12] Debug reset leaves cycle filter untouched.
// [RQ13] Debugger offset 0x47c; software lock makes read-only.
// [RQ14] Unpowered, locked or denied access returns error.
// [RQ15] Narrow system view hides bits 26 and 24.
// [RQ16] One event type register per counter, 0 to 30.
// [RQ17] Event bits 31 and 30 block kernel, user.
// [RQ18] Event nonsecure kernel needs bit29 equal bit31.
// [RQ19] Event nonsecure user needs bit28 equal bit30.
// [RQ20] Unimplemented event type reads zero, ignores writes.
// [RQ21] Event type fields are not reset on warm reset.
// [RQ22] Event bits 15 to 0 hold event number.
// [RQ23] Event hypervisor bits behave as cycle filter.
// [RQ24] Advance only when all applicable filter bits permit.
package pmu_filter_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CYCLE_FILTER = 12'h47c;
  localparam logic [11:0] OFF_EVENT_TYPE_BASE = 12'h400;
  localparam int MAX_COUNTERS = 31;
  localparam logic [4:0] SYS_SEL_CYCLE = 5'h1f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_KERNEL = 31;
  localparam int BIT_USER = 30;
  localparam int BIT_NONSECURE_KERNEL = 29;
  localparam int BIT_NONSECURE_USER = 28;
  localparam int BIT_HYPERVISOR = 27;
  localparam int BIT_MONITOR = 26;
  localparam int BIT_SECURE_HYPERVISOR = 24;
  localparam int BIT_ISOLATED_KERNEL = 22;
  localparam int BIT_ISOLATED_USER = 21;
  localparam int BIT_ISOLATED_HYPERVISOR = 20;
  localparam logic [31:0] EVENT_NUMBER_MASK = 32'h0000_ffff;
  localparam logic [31:0] NARROW_HIDDEN_MASK = 32'h0500_0000;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Privilege levels and worlds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_USER, LVL_KERNEL, LVL_HYPERVISOR, LVL_MONITOR
  } level_t;

  typedef enum logic [1:0] {
    WLD_SECURE, WLD_NONSECURE, WLD_ISOLATED, WLD_ROOT
  } world_t;

endpackage : pmu_filter_pkg

/* File: src/pmu_count_filter_regs.sv */
// Cycle filter and event type registers with their count permission logic.
`timescale 1ns/10ps
`default_nettype none

module pmu_count_filter_regs #(
  parameter int NUM_COUNTERS = pmu_filter_pkg::MAX_COUNTERS,
  parameter bit HAS_MONITOR = 1'b1,
  parameter bit HAS_HYPERVISOR = 1'b1,
  parameter bit HAS_SECURE_HYPERVISOR = 1'b1,
  parameter bit HAS_ISOLATED = 1'b1
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reset_narrow_state,
  input wire logic dbg_rst_n,
  // Access conditions
  input wire logic core_powered,
  input wire logic double_lock_set,
  input wire logic os_lock_set,
  input wire logic external_monitor_access_allowed,
  input wire logic software_lock_set,
  input wire logic secure_hyp_enabled,
  // External debug register port
  input wire logic dbg_req,
  input wire logic dbg_write,
  input wire logic [11:0] dbg_addr,
  input wire logic [31:0] dbg_wdata,
  output logic dbg_ack,
  output logic dbg_err,
  output logic [31:0] dbg_rdata,
  // System register port
  input wire logic sys_req,
  input wire logic sys_write,
  input wire logic sys_narrow,
  input wire logic [4:0] sys_sel,
  input wire logic [31:0] sys_wdata,
  output logic sys_ack,
  output logic [31:0] sys_rdata,
  // Current execution context and raw events
  input wire pmu_filter_pkg::level_t cur_level,
  input wire pmu_filter_pkg::world_t cur_world,
  input wire logic [pmu_filter_pkg::MAX_COUNTERS-1:0] event_hit,
  // Count permissions and selected events
  output logic cycle_count_en,
  output logic [pmu_filter_pkg::MAX_COUNTERS-1:0] event_count_en,
  output logic [pmu_filter_pkg::MAX_COUNTERS-1:0][15:0] event_number
);
  import pmu_filter_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cycle_filter;
    logic [MAX_COUNTERS-1:0][31:0] event_type;
    logic dbg_ack;
    logic dbg_err;
    logic [31:0] dbg_rdata;
    logic sys_ack;
    logic [31:0] sys_rdata;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // ----------------------------------------------------------------
  // Field masks from the implemented levels
  // ----------------------------------------------------------------
  logic [31:0] cycle_mask;
  logic [31:0] event_mask;

  always_comb begin
    cycle_mask = 32'h0000_0000;
    cycle_mask[BIT_KERNEL] = 1'b1; // [RQ1]
    cycle_mask[BIT_USER] = 1'b1; // [RQ2]
    cycle_mask[BIT_NONSECURE_KERNEL] = HAS_MONITOR; // [RQ3]
    cycle_mask[BIT_NONSECURE_USER] = HAS_MONITOR; // [RQ4]
    cycle_mask[BIT_HYPERVISOR] = HAS_HYPERVISOR; // [RQ5]
    cycle_mask[BIT_MONITOR] = HAS_MONITOR; // [RQ6]
    cycle_mask[BIT_SECURE_HYPERVISOR] = HAS_SECURE_HYPERVISOR &
      HAS_MONITOR & secure_hyp_enabled; // [RQ7]
    cycle_mask[BIT_ISOLATED_KERNEL] = HAS_ISOLATED; // [RQ8]
    cycle_mask[BIT_ISOLATED_USER] = HAS_ISOLATED; // [RQ9]
    cycle_mask[BIT_ISOLATED_HYPERVISOR] = HAS_ISOLATED; // [RQ10]
    event_mask = cycle_mask | EVENT_NUMBER_MASK; // [RQ22]
  end

  // ----------------------------------------------------------------
  // Count permission, shared by the cycle and every implemented event counter
  // ----------------------------------------------------------------
  function automatic logic permit(input logic [31:0] f, input level_t lvl,
                                  input world_t wld);
    logic ok;
    ok = 1'b0;
    case (lvl)
      LVL_USER: begin
        ok = !f[BIT_USER]; // [RQ2] [RQ17]
        if (HAS_MONITOR && wld == WLD_NONSECURE) begin
          ok = ok && (f[BIT_NONSECURE_USER] == f[BIT_USER]); // [RQ4] [RQ19]
        end
        if (HAS_ISOLATED && wld == WLD_ISOLATED) begin
          ok = ok && (f[BIT_ISOLATED_USER] == f[BIT_USER]); // [RQ9]
        end
      end
      LVL_KERNEL: begin
        ok = !f[BIT_KERNEL]; // [RQ1] [RQ17]
        if (HAS_MONITOR && wld == WLD_NONSECURE) begin
          ok = ok && (f[BIT_NONSECURE_KERNEL] == f[BIT_KERNEL]); // [RQ3] [RQ18]
        end
        if (HAS_ISOLATED && wld == WLD_ISOLATED) begin
          ok = ok && (f[BIT_ISOLATED_KERNEL] == f[BIT_KERNEL]); // [RQ8]
        end
      end
      LVL_HYPERVISOR: begin
        if (!HAS_HYPERVISOR) begin
          ok = 1'b0;
        end else if (wld == WLD_SECURE) begin
          ok = f[BIT_SECURE_HYPERVISOR] != f[BIT_HYPERVISOR]; // [RQ7] [RQ23]
        end else if (HAS_ISOLATED && wld == WLD_ISOLATED) begin
          ok = f[BIT_ISOLATED_HYPERVISOR] != f[BIT_HYPERVISOR]; // [RQ10] [RQ23]
        end else begin
          ok = f[BIT_HYPERVISOR]; // [RQ5] [RQ23]
        end
      end
      default: begin
        ok = HAS_MONITOR && (f[BIT_MONITOR] == f[BIT_KERNEL]); // [RQ6]
      end
    endcase
    return ok;
  endfunction : permit

  // Secure hypervisor is only a distinct state when it is enabled.
  logic sec_hyp_live;
  assign sec_hyp_live = HAS_SECURE_HYPERVISOR && HAS_MONITOR &&
                        secure_hyp_enabled;

  always_comb begin
    cycle_count_en = permit(state_r.cycle_filter & cycle_mask, cur_level,
                            cur_world) &&
                     !(cur_level == LVL_HYPERVISOR &&
                       cur_world == WLD_SECURE && !sec_hyp_live); // [RQ24]
  end

  genvar g;
  generate
    for (g = 0; g < MAX_COUNTERS; g++) begin : g_evt
      if (g < NUM_COUNTERS) begin : g_impl
        assign event_count_en[g] = event_hit[g] &&
          permit(state_r.event_type[g] & event_mask, cur_level, cur_world) &&
          !(cur_level == LVL_HYPERVISOR && cur_world == WLD_SECURE &&
            !sec_hyp_live); // [RQ24]
        assign event_number[g] = state_r.event_type[g][15:0]; // [RQ22]
      end else begin : g_none
        assign event_count_en[g] = 1'b0; // [RQ20]
        assign event_number[g] = 16'h0000;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // External access decode
  // ----------------------------------------------------------------
  logic dbg_open;
  logic dbg_hit_cycle;
  logic dbg_hit_event;
  logic [4:0] dbg_index;
  logic dbg_index_impl;

  always_comb begin
    dbg_open = core_powered && !double_lock_set && !os_lock_set &&
               external_monitor_access_allowed; // [RQ14]
    dbg_index = dbg_addr[6:2];
    dbg_hit_cycle = 1'b0;
    dbg_hit_event = 1'b0;
    if (dbg_addr == OFF_CYCLE_FILTER) begin
      dbg_hit_cycle = 1'b1; // [RQ13]
    end else if (dbg_addr[11:7] == OFF_EVENT_TYPE_BASE[11:7] &&
                 dbg_addr[1:0] == 2'b00) begin
      dbg_hit_event = 1'b1; // [RQ16]
    end
    dbg_index_impl = 32'(dbg_index) < NUM_COUNTERS;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.dbg_ack = 1'b0;
    state_nxt.dbg_err = 1'b0;
    state_nxt.sys_ack = 1'b0;

    // External debug access; sys access below wins on a same-cycle clash.
    if (dbg_req) begin
      state_nxt.dbg_ack = 1'b1;
      state_nxt.dbg_rdata = 32'h0000_0000;
      if (!dbg_open || !(dbg_hit_cycle || dbg_hit_event)) begin
        state_nxt.dbg_err = 1'b1; // [RQ14]
      end else if (dbg_hit_cycle) begin
        state_nxt.dbg_rdata = state_r.cycle_filter & cycle_mask; // [RQ13]
        if (dbg_write && !software_lock_set) begin
          state_nxt.cycle_filter = dbg_wdata & cycle_mask; // [RQ13]
        end
      end else if (dbg_index_impl) begin
        state_nxt.dbg_rdata = state_r.event_type[dbg_index] & event_mask;
        if (dbg_write && !software_lock_set) begin
          state_nxt.event_type[dbg_index] = dbg_wdata & event_mask; // [RQ16]
        end
      end
      // An unimplemented counter reads zero and drops the write. [RQ20]
    end

    // System register access.
    if (sys_req) begin
      state_nxt.sys_ack = 1'b1;
      state_nxt.sys_rdata = 32'h0000_0000;
      if (sys_sel == SYS_SEL_CYCLE) begin
        state_nxt.sys_rdata = state_r.cycle_filter & cycle_mask;
        if (sys_write) begin
          state_nxt.cycle_filter = sys_wdata & cycle_mask;
        end
      end else if (32'(sys_sel) < NUM_COUNTERS) begin
        state_nxt.sys_rdata = state_r.event_type[sys_sel] & event_mask;
        if (sys_write) begin
          state_nxt.event_type[sys_sel] = sys_wdata & event_mask;
        end
      end
      if (sys_narrow) begin
        // Hidden bits read zero and keep their value across a write.
        state_nxt.sys_rdata = state_nxt.sys_rdata & ~NARROW_HIDDEN_MASK; // [RQ15]
        if (sys_write && sys_sel == SYS_SEL_CYCLE) begin
          state_nxt.cycle_filter =
            (state_nxt.cycle_filter & ~NARROW_HIDDEN_MASK) |
            (state_r.cycle_filter & NARROW_HIDDEN_MASK); // [RQ15]
        end else if (sys_write && 32'(sys_sel) < NUM_COUNTERS) begin
          state_nxt.event_type[sys_sel] =
            (state_nxt.event_type[sys_sel] & ~NARROW_HIDDEN_MASK) |
            (state_r.event_type[sys_sel] & NARROW_HIDDEN_MASK); // [RQ15]
        end
      end
    end

    // A debug-only reset abandons a pending answer, never the filters.
    if (!dbg_rst_n) begin
      state_nxt.dbg_ack = 1'b0; // [RQ12]
      state_nxt.dbg_err = 1'b0;
      state_nxt.dbg_rdata = 32'h0000_0000;
    end

    // Warm or cold reset. Wide-state entry keeps the old, unknown, value.
    if (!rst_n) begin
      state_nxt.dbg_ack = 1'b0;
      state_nxt.dbg_err = 1'b0;
      state_nxt.dbg_rdata = 32'h0000_0000;
      state_nxt.sys_ack = 1'b0;
      state_nxt.sys_rdata = 32'h0000_0000;
      state_nxt.cycle_filter = reset_narrow_state ? RESET_VALUE
                                                  : state_r.cycle_filter; // [RQ11]
      state_nxt.event_type = state_r.event_type; // [RQ21]
    end
  end

  always_ff @(posedge mclk) begin
    state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dbg_ack = state_r.dbg_ack;
  assign dbg_err = state_r.dbg_err;
  assign dbg_rdata = state_r.dbg_rdata;
  assign sys_ack = state_r.sys_ack;
  assign sys_rdata = state_r.sys_rdata;

endmodule : pmu_count_filter_regs

`default_nettype wire

/* File: bench/pmu_filter_checker_assertions.sv */
// Concurrent checks on the ports of the counter filter register bank.
`timescale 1ns/10ps
`default_nettype none
module pmu_filter_checker
  import pmu_filter_pkg::*;
#(
  parameter int NUM_COUNTERS = 31
) (
  // Clock, resets and access conditions
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic dbg_rst_n,
  input wire logic core_powered,
  input wire logic double_lock_set,
  input wire logic os_lock_set,
  input wire logic external_monitor_access_allowed,
  input wire logic secure_hyp_enabled,
  // Watched requests, answers and permissions
  input wire logic dbg_req,
  input wire logic dbg_ack,
  input wire logic dbg_err,
  input wire logic sys_req,
  input wire logic sys_ack,
  input wire pmu_filter_pkg::level_t cur_level,
  input wire pmu_filter_pkg::world_t cur_world,
  input wire logic [MAX_COUNTERS-1:0] event_hit,
  input wire logic cycle_count_en,
  input wire logic [MAX_COUNTERS-1:0] event_count_en
);
  import pmu_filter_pkg::*;
  localparam logic [30:0] IMPL = (31'h1 << NUM_COUNTERS) - 31'h1;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence dbg_take;
    dbg_req && dbg_rst_n;
  endsequence
  // A closed port must still answer, so the error rides on the ack.
  sequence shut_take;
    dbg_take ##0 (!core_powered || double_lock_set || os_lock_set ||
      !external_monitor_access_allowed);
  endsequence
  answer_next_a: assert property (disable iff (!rst_n || !dbg_rst_n) dbg_take |=> dbg_ack)
    else $error("debug request not answered next cycle");
  no_stray_ack_a: assert property (!dbg_req |=> !dbg_ack)
    else $error("debug answer without request");
  err_with_ack_a: assert property (dbg_err |-> dbg_ack)
    else $error("debug error without answer");
  shut_error_a: assert property (disable iff (!rst_n || !dbg_rst_n) shut_take |=> dbg_err)
    else $error("closed access not refused");
  sys_answer_a: assert property (sys_req |=> sys_ack)
    else $error("system access not answered");
  hit_gates_a: assert property ((event_count_en & ~event_hit) == 31'h0)
    else $error("event count without event");
  unimpl_quiet_a: assert property ((event_count_en & ~IMPL) == 31'h0)
    else $error("absent counter enabled");
  sec_hyp_off_a: assert property (cur_level == LVL_HYPERVISOR &&
    cur_world == WLD_SECURE && !secure_hyp_enabled |-> !cycle_count_en)
    else $error("secure hypervisor counted while disabled");
endmodule : pmu_filter_checker
bind pmu_count_filter_regs pmu_filter_checker #(.NUM_COUNTERS(NUM_COUNTERS))
  u_chk (.mclk, .rst_n, .dbg_rst_n, .core_powered, .double_lock_set,
  .os_lock_set, .external_monitor_access_allowed, .secure_hyp_enabled,
  .dbg_req, .dbg_ack, .dbg_err, .sys_req, .sys_ack, .cur_level, .cur_world,
  .event_hit, .cycle_count_en, .event_count_en);
`default_nettype wire

/* File: bench/dbg_host_model.sv */
// Debugger model that drives the external debug register port.
`timescale 1ns/10ps
`default_nettype none
module dbg_host_model (
  // Clock and answer
  input wire logic mclk,
  input wire logic dbg_ack,
  input wire logic dbg_err,
  input wire logic [31:0] dbg_rdata,
  // Request
  output logic dbg_req,
  output logic dbg_write,
  output logic [11:0] dbg_addr,
  output logic [31:0] dbg_wdata
);
  initial {dbg_req, dbg_write, dbg_addr, dbg_wdata} = 46'h0;
  // Released lines are inverted so stale values never look valid.
  task automatic access(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int i;
    @(negedge mclk);
    dbg_req = 1'h1;
    dbg_write = w;
    dbg_addr = a;
    dbg_wdata = d;
    @(negedge mclk);
    dbg_req = 1'h0;
    dbg_write = ~w;
    dbg_addr = ~a;
    dbg_wdata = ~d;
    for (i = 0; i < 4 && dbg_ack !== 1'h1; i++) @(negedge mclk);
    q = dbg_rdata;
    e = (i < 4) ? dbg_err : 1'hx;
  endtask : access
endmodule : dbg_host_model
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the counter filter register bank.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pmu_filter_pkg::*;
  localparam int NC = 4;
  localparam logic [31:0] CMASK = 32'hfd70_0000;
  logic mclk = 1'h0, rst_n = 1'h0, reset_narrow_state = 1'h1;
  logic dbg_rst_n = 1'h1, core_powered = 1'h1, double_lock_set = 1'h0;
  logic os_lock_set = 1'h0, external_monitor_access_allowed = 1'h1;
  logic software_lock_set = 1'h0, secure_hyp_enabled = 1'h1, x;
  logic sys_req = 1'h0, sys_write = 1'h0, sys_narrow = 1'h0;
  logic [4:0] sys_sel = 5'h0;
  logic [31:0] sys_wdata = 32'h0, dbg_wdata, dbg_rdata, sys_rdata, q, v;
  level_t cur_level = LVL_USER;
  world_t cur_world = WLD_SECURE;
  logic [30:0] event_hit = 31'h0, event_count_en;
  logic [30:0][15:0] event_number;
  logic dbg_req, dbg_write, dbg_ack, dbg_err, sys_ack, cycle_count_en;
  logic [11:0] dbg_addr;
  int error_cnt = 0;
  int cmp_count = 0;
  pmu_count_filter_regs #(.NUM_COUNTERS(NC)) DUT (.mclk, .rst_n,
    .reset_narrow_state, .dbg_rst_n, .core_powered, .double_lock_set,
    .os_lock_set, .external_monitor_access_allowed, .software_lock_set,
    .secure_hyp_enabled, .dbg_req, .dbg_write, .dbg_addr, .dbg_wdata,
    .dbg_ack, .dbg_err, .dbg_rdata, .sys_req, .sys_write, .sys_narrow,
    .sys_sel, .sys_wdata, .sys_ack, .sys_rdata, .cur_level, .cur_world,
    .event_hit, .cycle_count_en, .event_count_en, .event_number);
  dbg_host_model host (.mclk, .dbg_ack, .dbg_err, .dbg_rdata, .dbg_req,
    .dbg_write, .dbg_addr, .dbg_wdata);
  always #10 mclk = ~mclk;
  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  function automatic logic permit(logic [31:0] r, level_t l, world_t w);
    logic ns;
    logic iso;
    ns = (w == WLD_NONSECURE);
    iso = (w == WLD_ISOLATED);
    case (l)
      LVL_USER: return !r[30] && !(ns && r[28] != r[30]) && !(iso && r[21] != r[30]);
      LVL_KERNEL: return !r[31] && !(ns && r[29] != r[31]) && !(iso && r[22] != r[31]);
      LVL_HYPERVISOR: return w == WLD_SECURE ? secure_hyp_enabled && r[24] != r[27] : iso ? r[20] != r[27] : r[27];
      default: return r[26] == r[31];
    endcase
  endfunction : permit
  task automatic dacc(logic w, logic [11:0] a, logic [31:0] d, logic ee, logic [31:0] er);
    logic e;
    host.access(w, a, d, q, e);
    chk(32'(e), 32'(ee), "debug error flag");
    if (e === 1'hx) stop_test();
    if (!w && !ee) chk(q, er, "debug read data");
  endtask : dacc
  task automatic sacc(logic w, logic [4:0] s, logic [31:0] d);
    @(negedge mclk);
    {sys_req, sys_write, sys_narrow, sys_sel, sys_wdata} = {1'h1, w, s == 5'h1f, s, d};
    @(negedge mclk);
    sys_req = 1'h0;
    chk(32'(sys_ack), 32'h1, "system answer");
  endtask : sacc
  initial begin
    void'($urandom(27201));
    repeat (5) @(negedge mclk);
    rst_n = 1'h1;
    dacc(0, 12'h47c, 0, 0, 32'h0);
    dacc(1, 12'h47c, '1, 0, 0);
    dacc(0, 12'h47c, 0, 0, CMASK);
    sacc(0, 5'h1f, 0);
    chk(sys_rdata, CMASK & ~NARROW_HIDDEN_MASK, "narrow view");
    sacc(1, 5'h1f, 0);
    software_lock_set = 1'h1;
    dacc(1, 12'h47c, 0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      {core_powered, double_lock_set, os_lock_set} = {i != 0, i == 1, i == 2};
      external_monitor_access_allowed = (i != 3);
      dacc(1, 12'h47c, 0, 1, 0);
    end
    {software_lock_set, external_monitor_access_allowed} = 2'h1;
    dacc(0, 12'h480, 0, 1, 0);
    dacc(0, 12'h47c, 0, 0, NARROW_HIDDEN_MASK);
    for (int n = 0; n <= NC; n++) begin
      v = $urandom();
      dacc(1, 12'h400 + 12'(4 * n), v, 0, 0);
      v = (n < NC) ? v & (CMASK | EVENT_NUMBER_MASK) : 32'h0;
      dacc(0, 12'h400 + 12'(4 * n), 0, 0, v);
      chk(32'(event_number[n]), 32'(v[15:0]), "event number");
      sacc(0, 5'(n), 0);
      chk(sys_rdata, v, "event type system view");
    end
    repeat (40) begin
      secure_hyp_enabled = 1'h1;
      v = $urandom() & CMASK;
      dacc(1, 12'h47c, v, 0, 0);
      dacc(1, 12'h400, v, 0, 0);
      repeat (8) begin
        @(negedge mclk);
        cur_level = level_t'($urandom_range(3));
        cur_world = world_t'($urandom_range(3));
        secure_hyp_enabled = 1'($urandom());
        event_hit = 31'($urandom());
        #1;
        x = permit(v, cur_level, cur_world);
        chk(32'(cycle_count_en), 32'(x), "cycle permit");
        chk(32'(event_count_en[0]), 32'(x & event_hit[0]), "event permit");
      end
    end
    {secure_hyp_enabled, dbg_rst_n} = 2'h2;
    repeat (2) @(negedge mclk);
    dbg_rst_n = 1'h1;
    dacc(0, 12'h47c, 0, 0, v);
    // Wide-state entry: the filters must come through the reset intact.
    {rst_n, reset_narrow_state} = 2'h0;
    repeat (2) @(negedge mclk);
    rst_n = 1'h1;
    dacc(0, 12'h47c, 0, 0, v);
    dacc(0, 12'h400, 0, 0, v);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("BAD %0t run did not finish", $time);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
